// [rtl/mbx_unit.v]
`timescale 1ns/10ps
`include "mbx_defines.vh"
// Functional notes
// - Reset loads bank-return stack pointer with 7F.
// - Pointer increments before a call push, decrements after a return pop.
// - Stack holds 128 bytes; pointer bit 7 always reads zero.
// - Pointer wrap or overflow raises no flag at all.
// - Fetches outside interrupt routines take their upper address bits from the current bank.
// - Long jump copies next bank into current bank for the next fetch.
// - Long jump leaves the next-bank field unchanged.
// - Interrupt routines fetch from the interrupt bank, whatever current is.
// - Constant reads use current or constant bank, per select bit.
// - External data moves use current or data bank, per select bit.
// - Relative and short absolute jumps never touch the current bank.
// - Call: increment, push control register at pointer, then copy bank.
// - Return: read at pointer, load control register, then decrement.
// - Bank stack updates in the same instruction as the normal stack.
// - Pin high: internal fetch, external only beyond internal range.
// - Pin low: external fetch, except boot, XRAM and data ranges.
// - Boot code sits at address 0000 until software switches the map.
// - Post-increment pointer store writes program memory.
// - Bytes 20 to 2F are bit addressable, bit 00 at byte 20 bit 0.
// - Upper 128 addresses: indirect picks RAM, direct picks registers.
// - Reset sets the ordinary stack pointer to 07.
// - External moves use 8 or 16 bit address plus 4-bit bank.
module mbx_unit
(
  input  wire        clk,
  input  wire        srst,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata_r,
  input  wire        ljmp_exec,
  input  wire        lcall_exec,
  input  wire        acall_exec,
  input  wire        int_entry,
  input  wire        ret_exec,
  input  wire        in_isr,
  input  wire        fetch_req,
  input  wire [15:0] fetch_pc,
  input  wire        external_fetch_pin_n,
  input  wire        movc_req,
  input  wire        movc_wr,
  input  wire [15:0] movc_addr,
  input  wire [7:0]  movc_wdata,
  input  wire        movx_req,
  input  wire        movx_narrow,
  input  wire [7:0]  movx_page,
  input  wire [15:0] movx_addr,
  input  wire        dm_req,
  input  wire [7:0]  dm_addr,
  input  wire        dm_indirect,
  input  wire        dm_bit,
  output reg         fetch_vld_r,
  output reg  [19:0] fetch_addr_r,
  output reg         fetch_ext_r,
  output reg         fetch_boot_r,
  output reg         code_rd_r,
  output reg         code_wr_r,
  output reg  [19:0] code_addr_r,
  output reg  [7:0]  code_wdata_r,
  output reg         xd_vld_r,
  output reg  [19:0] xd_addr_r,
  output reg         stk_we_r,
  output reg         stk_re_r,
  output reg  [6:0]  stk_addr_r,
  output reg  [7:0]  stk_data_r,
  output reg  [7:0]  current_bank_r,
  output reg  [7:0]  sp_r,
  output reg         dm_vld_r,
  output reg         dm_ram_sel_r,
  output reg         dm_sfr_sel_r,
  output reg  [7:0]  dm_byte_r,
  output reg  [2:0]  dm_pos_r
);

  // Architectural registers
  reg  [7:0] brsp_r;
  reg  [7:0] code_bank_control_r;
  reg  [7:0] reg_two_r;
  reg  [7:0] reg_three_r;
  reg  [3:0] interrupt_bank_r;
  reg        map_std_r;
  reg  [7:0] ret_stack [0:127];

  // Pin synchroniser for the external fetch pin
  reg        xfp_s1_r;
  reg        xfp_s2_r;

  wire [3:0] current_bank;
  wire [3:0] next_bank;
  wire [3:0] constant_bank;
  wire [3:0] external_data_bank;
  wire       constant_bank_select;
  wire       external_data_bank_select;
  wire       push;
  wire [7:0] brsp_inc;
  wire [7:0] brsp_dec;
  wire [7:0] pop_data;

  // Field views of the bank registers
  assign current_bank  = code_bank_control_r[`MBX_CUR_HI:`MBX_CUR_LO];
  assign next_bank     = code_bank_control_r[`MBX_NXT_HI:`MBX_NXT_LO];
  assign constant_bank = reg_two_r[`MBX_NXT_HI:`MBX_NXT_LO];
  assign external_data_bank = reg_three_r[`MBX_CUR_HI:`MBX_CUR_LO];
  assign constant_bank_select = reg_two_r[`MBX_CBS_BIT];
  assign external_data_bank_select = reg_three_r[`MBX_XSEL_BIT];

  // Any kind of call pushes the same way
  assign push = lcall_exec | acall_exec | int_entry;
  // Masking keeps wrap silent and bit 7 clear
  assign brsp_inc = (brsp_r + `MBX_ONE8) & `MBX_BRSP_MASK;
  assign brsp_dec = (brsp_r - `MBX_ONE8) & `MBX_BRSP_MASK;
  assign pop_data = ret_stack[brsp_r[6:0]];

  // Two flops before the pin is used
  always @(posedge clk)
  begin
    if (srst)
    begin
      xfp_s1_r <= 1'b1;
      xfp_s2_r <= 1'b1;
    end
    else
    begin
      xfp_s1_r <= external_fetch_pin_n;
      xfp_s2_r <= xfp_s1_r;
    end
  end

  // Bank-return stack storage, no reset needed
  always @(posedge clk)
  begin
    if (!srst && push)
      ret_stack[brsp_inc[6:0]] <= code_bank_control_r;
  end

  // Register file; instruction effects override software writes
  always @(posedge clk)
  begin
    if (srst)
    begin
      brsp_r              <= `MBX_BRSP_RST;
      code_bank_control_r <= `MBX_CBC_RST;
      reg_two_r           <= `MBX_REG_RST;
      reg_three_r         <= `MBX_REG_RST;
      interrupt_bank_r    <= `MBX_BANK_RST;
      map_std_r           <= 1'b0;
      sp_r                <= `MBX_SP_RST;
    end
    else
    begin
      if (reg_wr)
      begin
        case (reg_addr)
          `MBX_A_BRSP:
            brsp_r <= reg_wdata & `MBX_BRSP_MASK;
          `MBX_A_CBC:
            code_bank_control_r <= reg_wdata;
          `MBX_A_REG2:
            reg_two_r <= reg_wdata;
          `MBX_A_REG3:
            reg_three_r <= {reg_wdata[7:3], `MBX_ZERO3};
          `MBX_A_IBANK:
            interrupt_bank_r <= reg_wdata[3:0];
          `MBX_A_MAP:
            map_std_r <= reg_wdata[`MBX_MAP_BIT];
          `MBX_A_SP:
            sp_r <= reg_wdata;
          default:
            sp_r <= sp_r;
        endcase
      end
      // Push and bank switch happen with the core's own stack push
      if (push)
      begin
        brsp_r <= brsp_inc;
        if (int_entry)
          code_bank_control_r[`MBX_CUR_HI:`MBX_CUR_LO] <=
            interrupt_bank_r;
        else
          code_bank_control_r[`MBX_CUR_HI:`MBX_CUR_LO] <=
            next_bank;
      end
      else if (ret_exec)
      begin
        code_bank_control_r <= pop_data;
        brsp_r              <= brsp_dec;
      end
      else if (ljmp_exec)
      begin
        // Only the high nibble moves; short jumps have no path here
        code_bank_control_r[`MBX_CUR_HI:`MBX_CUR_LO] <=
          next_bank;
      end
    end
  end

  // Stack traffic made visible, one cycle behind
  always @(posedge clk)
  begin
    if (srst)
    begin
      stk_we_r   <= 1'b0;
      stk_re_r   <= 1'b0;
      stk_addr_r <= 7'h00;
      stk_data_r <= 8'h00;
    end
    else
    begin
      stk_we_r <= push;
      stk_re_r <= ret_exec & ~push;
      if (push)
      begin
        stk_addr_r <= brsp_inc[6:0];
        stk_data_r <= code_bank_control_r;
      end
      else if (ret_exec)
      begin
        stk_addr_r <= brsp_r[6:0];
        stk_data_r <= pop_data;
      end
    end
  end

  // Fetch address and internal or external decode
  reg  [3:0]  fetch_bank;
  reg  [19:0] fetch_full;
  reg         boot_hit;
  reg         always_int;
  reg         fetch_ext;
  always @*
  begin
    fetch_bank = in_isr ? interrupt_bank_r : current_bank;
    fetch_full = {fetch_bank, fetch_pc};
    boot_hit   = ~map_std_r && (fetch_full <= `MBX_BOOT_TOP);
    always_int = boot_hit ||
                 ((fetch_full >= `MBX_XRAM_LO) &&
                  (fetch_full <= `MBX_XRAM_HI)) ||
                 ((fetch_full >= `MBX_DFL_LO) &&
                  (fetch_full <= `MBX_DFL_HI));
    if (xfp_s2_r)
      fetch_ext = ~always_int && (fetch_full > `MBX_INT_TOP) &&
                  `MBX_EXT_BUS;
    else
      fetch_ext = ~always_int;
  end

  // Fetch outputs
  always @(posedge clk)
  begin
    if (srst)
    begin
      fetch_vld_r  <= 1'b0;
      fetch_addr_r <= 20'h0_0000;
      fetch_ext_r  <= 1'b0;
      fetch_boot_r <= 1'b0;
    end
    else
    begin
      fetch_vld_r <= fetch_req;
      if (fetch_req)
      begin
        fetch_addr_r <= fetch_full;
        fetch_ext_r  <= fetch_ext;
        fetch_boot_r <= boot_hit;
      end
    end
  end

  // Constant reads and program memory writes
  wire [3:0] code_bank;
  assign code_bank = constant_bank_select ? constant_bank
                                          : current_bank;
  always @(posedge clk)
  begin
    if (srst)
    begin
      code_rd_r    <= 1'b0;
      code_wr_r    <= 1'b0;
      code_addr_r  <= 20'h0_0000;
      code_wdata_r <= 8'h00;
    end
    else
    begin
      code_rd_r <= movc_req & ~movc_wr;
      code_wr_r <= movc_req & movc_wr;
      if (movc_req)
      begin
        code_addr_r  <= {code_bank, movc_addr};
        code_wdata_r <= movc_wdata;
      end
    end
  end

  // External data address; narrow form takes its page from outside
  wire [3:0]  xd_bank;
  wire [15:0] xd_off;
  assign xd_bank = external_data_bank_select ? external_data_bank
                                             : current_bank;
  assign xd_off  = movx_narrow ? {movx_page, movx_addr[7:0]}
                               : movx_addr;
  always @(posedge clk)
  begin
    if (srst)
    begin
      xd_vld_r  <= 1'b0;
      xd_addr_r <= 20'h0_0000;
    end
    else
    begin
      xd_vld_r <= movx_req;
      if (movx_req)
        xd_addr_r <= {xd_bank, xd_off};
    end
  end

  // Internal data space decode
  reg       dm_ram;
  reg [7:0] dm_byte;
  reg [2:0] dm_pos;
  always @*
  begin
    dm_ram  = 1'b1;
    dm_byte = dm_addr;
    dm_pos  = dm_addr[2:0];
    if (dm_bit)
    begin
      if (!dm_addr[`MBX_HI_BIT])
        dm_byte = `MBX_BIT_BASE + {4'h0, dm_addr[6:3]};
      else
      begin
        dm_byte = {dm_addr[7:3], `MBX_ZERO3};
        dm_ram  = 1'b0;
      end
    end
    else if (dm_addr[`MBX_HI_BIT])
      dm_ram = dm_indirect;
  end

  always @(posedge clk)
  begin
    if (srst)
    begin
      dm_vld_r     <= 1'b0;
      dm_ram_sel_r <= 1'b0;
      dm_sfr_sel_r <= 1'b0;
      dm_byte_r    <= 8'h00;
      dm_pos_r     <= 3'h0;
    end
    else
    begin
      dm_vld_r     <= dm_req;
      dm_ram_sel_r <= dm_req & dm_ram;
      dm_sfr_sel_r <= dm_req & ~dm_ram;
      if (dm_req)
      begin
        dm_byte_r <= dm_byte;
        dm_pos_r  <= dm_pos;
      end
    end
  end

  // Read data one cycle after the strobe, zero elsewhere
  always @(posedge clk)
  begin
    if (srst)
    begin
      reg_rdata_r    <= 8'h00;
      current_bank_r <= `MBX_CBC_RST;
    end
    else
    begin
      current_bank_r <= code_bank_control_r;
      reg_rdata_r    <= 8'h00;
      if (reg_rd)
      begin
        case (reg_addr)
          `MBX_A_BRSP:
            reg_rdata_r <= brsp_r & `MBX_BRSP_MASK;
          `MBX_A_CBC:
            reg_rdata_r <= code_bank_control_r;
          `MBX_A_REG2:
            reg_rdata_r <= reg_two_r;
          `MBX_A_REG3:
            reg_rdata_r <= reg_three_r;
          `MBX_A_IBANK:
            reg_rdata_r <= {4'h0, interrupt_bank_r};
          `MBX_A_MAP:
            reg_rdata_r <= {7'h00, map_std_r};
          `MBX_A_SP:
            reg_rdata_r <= sp_r;
          default:
            reg_rdata_r <= 8'h00;
        endcase
      end
    end
  end

endmodule

// [rtl/mbx_defines.vh]
`ifndef MBX_DEFINES_VH
`define MBX_DEFINES_VH

// Register port offsets
`define MBX_A_BRSP      8'h00
`define MBX_A_CBC       8'h01
`define MBX_A_REG2      8'h02
`define MBX_A_REG3      8'h03
`define MBX_A_IBANK     8'h04
`define MBX_A_MAP       8'h05
`define MBX_A_SP        8'h06

// Reset values
`define MBX_BRSP_RST    8'h7F
`define MBX_SP_RST      8'h07
`define MBX_CBC_RST     8'h00
`define MBX_REG_RST     8'h00
`define MBX_BANK_RST    4'h0

// Pointer mask keeps bit 7 at zero
`define MBX_BRSP_MASK   8'h7F
`define MBX_ONE8        8'h01

// Field positions
`define MBX_CUR_HI      7
`define MBX_CUR_LO      4
`define MBX_NXT_HI      3
`define MBX_NXT_LO      0
`define MBX_CBS_BIT     7
`define MBX_XSEL_BIT    3
`define MBX_MAP_BIT     0

// Code space ranges, full 20-bit addresses
`define MBX_INT_TOP     20'h0_7FFF
`define MBX_BOOT_TOP    20'h0_0FFF
`define MBX_XRAM_LO     20'h0_F000
`define MBX_XRAM_HI     20'h0_F7FF
`define MBX_DFL_LO      20'h0_A000
`define MBX_DFL_HI      20'h0_AFFF
`define MBX_EXT_BUS     1'b1

// Internal data space
`define MBX_BIT_BASE    8'h20
`define MBX_HI_BIT      7
`define MBX_ZERO3       3'h0

`endif

// [testbench/mbx_properties.sv]
`timescale 1ns/10ps
module mbx_props
(
  input logic        clk,
  input logic        srst,
  input logic        reg_wr,
  input logic        ljmp_exec,
  input logic        lcall_exec,
  input logic        acall_exec,
  input logic        int_entry,
  input logic        ret_exec,
  input logic        in_isr,
  input logic        fetch_req,
  input logic [15:0] fetch_pc,
  input logic        movc_req,
  input logic        movc_wr,
  input logic [7:0]  movc_wdata,
  input logic        movx_req,
  input logic        dm_req,
  input logic        xd_vld_r,
  input logic        dm_vld_r,
  input logic        dm_ram_sel_r,
  input logic        dm_sfr_sel_r,
  input logic        fetch_vld_r,
  input logic [19:0] fetch_addr_r,
  input logic        code_wr_r,
  input logic        code_rd_r,
  input logic [7:0]  code_wdata_r,
  input logic        stk_we_r,
  input logic        stk_re_r,
  input logic [6:0]  stk_addr_r,
  input logic [7:0]  stk_data_r,
  input logic [7:0]  current_bank_r
);
  default clocking dck @(posedge clk);
  endclocking
  default disable iff (srst);
  // Event decode; push outranks pop, both outrank a long jump
  wire push  = lcall_exec | acall_exec | int_entry;
  wire pop   = ret_exec & ~push;
  wire jmp   = ljmp_exec & ~push & ~ret_exec & ~reg_wr;
  wire quiet = ~push & ~ret_exec & ~ljmp_exec & ~reg_wr;
  sequence s_push;
    push;
  endsequence
  sequence s_pop;
    pop;
  endsequence
  AST_PUSH: assert property (s_push |=> stk_we_r && !stk_re_r)
    else $error("push gave no stack write");
  AST_POP: assert property (s_pop |=> stk_re_r && !stk_we_r)
    else $error("pop gave no stack read");
  AST_PUSH_SEQ: assert property (s_push ##1 s_push |=>
    stk_addr_r == $past(stk_addr_r) + 7'h01) else $error("no pre-increment");
  AST_PUSH_POP: assert property (s_push ##1 s_pop |=>
    stk_addr_r == $past(stk_addr_r) && stk_data_r == $past(stk_data_r))
    else $error("pop does not return pushed byte");
  AST_LJMP: assert property (jmp ##1 quiet |=>
    current_bank_r[7:4] == current_bank_r[3:0]) else $error("bank not copied");
  AST_FETCH: assert property (fetch_req && !in_isr |=> fetch_vld_r &&
    fetch_addr_r == {current_bank_r[7:4], $past(fetch_pc)})
    else $error("fetch address wrong");
  AST_MOVC_WR: assert property (movc_req && movc_wr |=> code_wr_r &&
    !code_rd_r && code_wdata_r == $past(movc_wdata)) else $error("no write");
  AST_MOVC_RD: assert property (movc_req && !movc_wr |=>
    code_rd_r && !code_wr_r) else $error("constant read missing");
  AST_XD_VLD: assert property (movx_req |=> xd_vld_r)
    else $error("data move gave no strobe");
  AST_DM_SEL: assert property (dm_req |=> dm_vld_r &&
    (dm_ram_sel_r != dm_sfr_sel_r)) else $error("no single space picked");
endmodule
bind mbx_unit mbx_props u_mbx_props (.*);

// [testbench/mbx_seq_model.sv]
`timescale 1ns/10ps
// Sequencer stand-in: strobes instruction events and code fetches
module mbx_seq_model
(
  input  logic        clk,
  output logic [4:0]  ev = 5'h00,
  output logic        fetch_req = 1'b0,
  output logic [15:0] fetch_pc = 16'h0000
);
  // One or two events on consecutive cycles, one strobe per instruction
  task op(input [4:0] e1, input [4:0] e2);
  begin
    @(posedge clk);
    ev <= e1;
    @(posedge clk);
    ev <= e2;
    if (e2 != 5'h00)
    begin
      @(posedge clk);
      ev <= 5'h00;
    end
    #1;
  end
  endtask
  // Pc is scrambled once the strobe drops, so stale reuse shows up
  task fetch(input [15:0] pc);
  begin
    @(posedge clk);
    fetch_req <= 1'b1;
    fetch_pc <= pc;
    @(posedge clk);
    fetch_req <= 1'b0;
    fetch_pc <= ~pc;
  end
  endtask
endmodule

// [testbench/tb_memory_bank_extension_unit.sv]
`timescale 1ns/10ps
module tb_memory_bank_extension_unit;
  typedef struct packed {logic [7:0] r1, r2, r3; logic [2:0] k;
    logic [15:0] a; logic [19:0] e;} mbx_row_t;
  logic        clk, srst, reg_wr, reg_rd, in_isr, external_fetch_pin_n;
  logic        movc_req, movc_wr, movx_req, movx_narrow, dm_req, dm_bit;
  logic        dm_indirect, fetch_vld_r, fetch_ext_r, fetch_boot_r;
  logic        code_rd_r, code_wr_r, xd_vld_r, stk_we_r, stk_re_r, dm_vld_r;
  logic        dm_ram_sel_r, dm_sfr_sel_r, fetch_req;
  logic        ljmp_exec, lcall_exec, acall_exec, int_entry, ret_exec;
  logic [4:0]  ev;
  logic [7:0]  reg_addr, reg_wdata, movc_wdata, movx_page, dm_addr, sp_r;
  logic [7:0]  reg_rdata_r, code_wdata_r, stk_data_r, current_bank_r;
  logic [7:0]  dm_byte_r;
  logic [15:0] movc_addr, movx_addr, fetch_pc;
  logic [19:0] fetch_addr_r, code_addr_r, xd_addr_r;
  logic [6:0]  stk_addr_r;
  logic [2:0]  dm_pos_r;
  int          bad_count, n_compared, t;
  // Bank selection cases: registers, request kind, offset, full address
  mbx_row_t    rows [6] = '{
    '{8'h30, 8'h00, 8'h00, 3'h0, 16'h1234, 20'h3_1234},
    '{8'h30, 8'h85, 8'h00, 3'h1, 16'h0100, 20'h5_0100},
    '{8'h30, 8'h05, 8'h00, 3'h1, 16'h0100, 20'h3_0100},
    '{8'h30, 8'h00, 8'h98, 3'h2, 16'hABCD, 20'h9_ABCD},
    '{8'h30, 8'h00, 8'h90, 3'h2, 16'hABCD, 20'h3_ABCD},
    '{8'h30, 8'h00, 8'h98, 3'h3, 16'h5678, 20'h9_5678}};
  assign {ljmp_exec, lcall_exec, acall_exec, int_entry, ret_exec} = ev;
  mbx_unit dut (.*);
  mbx_seq_model sq
  (
    .clk       (clk),
    .ev        (ev),
    .fetch_req (fetch_req),
    .fetch_pc  (fetch_pc)
  );
  // Core clock, 10 ns period
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task chk(input [19:0] got, input [19:0] exp);
  begin
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  // Register bus: one-cycle strobes, read data only in the next cycle
  task wr(input [7:0] a, input [7:0] v);
  begin
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  end
  endtask
  task rd(input [7:0] a, input [7:0] exp);
  begin
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk({12'h000, reg_rdata_r}, {12'h000, exp});
  end
  endtask
  // Kinds: 0 fetch, 1 constant read, 2/3 wide/narrow data, 4 code write, 5 dm
  task go(input [2:0] k, input [15:0] a);
  begin
    if (k == 3'h0)
      sq.fetch(a);
    else
    begin
      @(posedge clk);
      movc_addr <= a;
      movx_addr <= (k == 3'h3) ? {8'hEE, a[7:0]} : a;
      movx_page <= a[15:8];
      dm_addr <= a[7:0];
      movc_req <= (k == 3'h1) || (k == 3'h4);
      movc_wr <= (k == 3'h4);
      movx_req <= (k == 3'h2) || (k == 3'h3);
      movx_narrow <= (k == 3'h3);
      dm_req <= (k == 3'h5);
      @(posedge clk);
      {movc_req, movx_req, dm_req} <= 3'h0;
    end
    #1;
  end
  endtask
  function logic [19:0] sv();
    sv = {3'h0, stk_we_r, stk_re_r, stk_addr_r, stk_data_r};
  endfunction
  function logic [19:0] fb();
    fb = {16'h0000, dm_ram_sel_r, dm_sfr_sel_r, fetch_boot_r, fetch_ext_r};
  endfunction
  task td;
  begin
    t++;
    $display("Test %0d done", t);
  end
  endtask
  task close_out;
  begin
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask
  // Main sequence: table first, then reset and the awkward cases
  initial
  begin
    {srst, external_fetch_pin_n, reg_wr, reg_rd, in_isr, dm_bit} = 6'h30;
    {movc_req, movc_wr, movx_req, movx_narrow, dm_req, dm_indirect} = 6'h00;
    {reg_addr, reg_wdata, movx_page, dm_addr} = 32'h0000_0000;
    {movc_addr, movx_addr} = 32'h0000_0000;
    movc_wdata = 8'hC3;
    {bad_count, n_compared, t} = 0;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    foreach (rows[i])
    begin
      wr(8'h01, rows[i].r1);
      wr(8'h02, rows[i].r2);
      wr(8'h03, rows[i].r3);
      go(rows[i].k, rows[i].a);
      chk(rows[i].k == 3'h0 ? fetch_addr_r : rows[i].k == 3'h1 ?
          code_addr_r : xd_addr_r, rows[i].e);
    end
    td;
    @(posedge clk);
    srst <= 1'b1;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    rd(8'h00, 8'h7F);
    rd(8'h06, 8'h07);
    chk({12'h000, sp_r}, 20'h0_0007);
    rd(8'h01, 8'h00);
    rd(8'h40, 8'h00);
    go(3'h0, 16'h0010);
    chk(fb(), 20'h0_0002);
    wr(8'h00, 8'hFF);
    rd(8'h00, 8'h7F);
    td;
    wr(8'h01, 8'h12);
    sq.op(5'h08, 5'h00);
    chk(sv(), 20'h1_0012);
    rd(8'h01, 8'h22);
    wr(8'h04, 8'h06);
    sq.op(5'h02, 5'h04);
    chk(sv(), 20'h1_0262);
    sq.op(5'h04, 5'h01);
    chk(sv(), 20'h0_8322);
    sq.op(5'h01, 5'h01);
    chk(sv(), 20'h0_8122);
    rd(8'h00, 8'h00);
    sq.op(5'h01, 5'h00);
    chk(sv(), 20'h0_8012);
    rd(8'h00, 8'h7F);
    td;
    wr(8'h01, 8'h5A);
    sq.op(5'h10, 5'h00);
    rd(8'h01, 8'hAA);
    go(3'h0, 16'h0100);
    chk(fetch_addr_r, 20'hA_0100);
    @(posedge clk);
    in_isr <= 1'b1;
    go(3'h0, 16'h0040);
    chk(fetch_addr_r, 20'h6_0040);
    @(posedge clk);
    in_isr <= 1'b0;
    wr(8'h01, 8'h00);
    wr(8'h05, 8'h01);
    go(3'h0, 16'h0010);
    chk(fb(), 20'h0_0000);
    go(3'h0, 16'h9000);
    chk(fb(), 20'h0_0001);
    @(posedge clk);
    external_fetch_pin_n <= 1'b0;
    repeat (3) @(posedge clk);
    go(3'h0, 16'h1000);
    chk(fb(), 20'h0_0001);
    go(3'h0, 16'hA010);
    chk(fb(), 20'h0_0000);
    @(posedge clk);
    external_fetch_pin_n <= 1'b1;
    td;
    go(3'h4, 16'h2222);
    chk({11'h000, code_wr_r, code_wdata_r}, 20'h0_01C3);
    @(posedge clk);
    dm_bit <= 1'b1;
    go(3'h5, 16'h000B);
    chk({7'h00, dm_ram_sel_r, dm_sfr_sel_r, dm_byte_r, dm_pos_r},
        20'h0_110B);
    go(3'h5, 16'h0087);
    chk({7'h00, dm_ram_sel_r, dm_sfr_sel_r, dm_byte_r, dm_pos_r},
        20'h0_0C07);
    @(posedge clk);
    {dm_bit, dm_indirect} <= 2'h1;
    go(3'h5, 16'h0090);
    chk(fb() >> 2, 20'h0_0002);
    @(posedge clk);
    dm_indirect <= 1'b0;
    go(3'h5, 16'h0090);
    chk(fb() >> 2, 20'h0_0001);
    td;
    close_out;
  end
endmodule
